// ### rtl/lsft_pkg.sv
// Constants and carrier types shared by the load/store forward throttle.
package lsft_pkg;

   localparam int LINE_OFS_W  = 6;
   localparam int CHUNK_OFS_W = 2;
   localparam int LINE_CHUNKS = 16;
   localparam int ALIAS_BITS  = 12;
   localparam int SB_DEPTH    = 4;
   localparam int GAP_W       = 4;

   localparam logic [2:0]       FWD_MAX_LOG = 3'h3;
   localparam logic [2:0]       WORD_LOG    = 3'h2;
   localparam logic [GAP_W-1:0] GAP_FREE    = 4'h1;
   localparam logic [GAP_W-1:0] GAP_FAST    = 4'h2;
   localparam logic [GAP_W-1:0] GAP_SLOW    = 4'h9;
   localparam logic [31:0]      SP_RST      = 32'h0000_0000;

   typedef enum logic [1:0] {
      KIND_ALU    = 2'b00,
      KIND_MEM    = 2'b01,
      KIND_FPPIPE = 2'b10
   } lsft_kind_type;

   typedef enum logic [2:0] {
      DATA_SEGMENT        = 3'b000,
      EXTRA_SEGMENT_F     = 3'b001,
      EXTRA_SEGMENT_G     = 3'b010,
      STRING_DEST_SEGMENT = 3'b011,
      CODE_SEGMENT        = 3'b100,
      STACK_SEGMENT       = 3'b101
   } lsft_seg_type;

   typedef enum logic [0:0] {
      ST_RUN  = 1'b0,
      ST_LONG = 1'b1
   } lsft_state_type;

   typedef struct packed {
      logic          valid;
      lsft_kind_type kind;
      logic          is_store;
      logic          is_int;
      lsft_seg_type  seg;
      logic          str_dst;
      logic          push;
      logic          pop;
      logic [2:0]    size_log;
      logic [31:0]   base;
      logic [31:0]   addr;
      logic [63:0]   data;
   } lsft_op_type;

   typedef struct packed {
      logic        valid;
      logic        is_int;
      logic [2:0]  size_log;
      logic [31:0] addr;
      logic [63:0] data;
   } lsft_sb_type;

   typedef struct packed {
      logic        valid;
      logic [2:0]  size_log;
      logic [31:0] addr;
   } lsft_req_type;

endpackage

// ### rtl/lsft_throttle.sv
// Per-pipeline spacing counter for memory operations.
`timescale 1ns/1ps
`default_nettype none
module lsft_throttle (
   input  wire logic                    clk_i,     // Core clock.
   input  wire logic                    sys_rst_i, // Asynchronous reset, high.
   input  wire logic [lsft_pkg::GAP_W-1:0] gap_i,  // Spacing the pending op needs.
   input  wire logic                    fire_i,    // Memory op issues this cycle.
   output logic                         ready_o    // Spacing satisfied.
);
   import lsft_pkg::*;

   logic [GAP_W-1:0] since_r;
   logic [GAP_W-1:0] last_r;
   logic [GAP_W-1:0] since_nxt;

   // A new op waits both for its own spacing and for that of the previous op.
   assign ready_o   = (since_r >= gap_i) && (since_r >= last_r); // RQ18
   assign since_nxt = fire_i ? GAP_FREE
                    : (&since_r) ? since_r : since_r + GAP_FREE;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         since_r <= '1;
         last_r  <= GAP_FREE;
      end else begin
         since_r <= since_nxt;
         if (fire_i) begin
            last_r <= gap_i; // RQ18
         end
      end
   end

   a_slow_gap: assert property ( // RQ8
      @(posedge clk_i) disable iff (sys_rst_i)
      fire_i && gap_i == GAP_SLOW |=> !fire_i [*8])
      else $error("slow segment op issued inside nine cycles");

   a_fast_gap: assert property ( // RQ9
      @(posedge clk_i) disable iff (sys_rst_i)
      fire_i && gap_i == GAP_FAST |=> !fire_i)
      else $error("fast segment op issued inside two cycles");

endmodule
`default_nettype wire

// ### rtl/lsft_fwd_cmp.sv
// Compares one store buffer entry against a load for forwarding.
`timescale 1ns/1ps
`default_nettype none
module lsft_fwd_cmp (
   input  wire lsft_pkg::lsft_sb_type ent_i,     // Store buffer entry.
   input  wire logic [31:0]           addr_i,    // Load linear address.
   input  wire logic [2:0]            size_log_i,// Load size, log2 bytes.
   input  wire logic                  int_i,     // Load is integer.
   output logic                       overlap_o, // Bytes overlap.
   output logic                       exact_o    // Entry may forward.
);
   import lsft_pkg::*;

   logic [ALIAS_BITS:0] st_lo;
   logic [ALIAS_BITS:0] st_hi;
   logic [ALIAS_BITS:0] ld_lo;
   logic [ALIAS_BITS:0] ld_hi;

   // Only the low address bits take part, so aliases look like hits.
   assign st_lo = {1'b0, ent_i.addr[ALIAS_BITS-1:0]}; // RQ4
   assign ld_lo = {1'b0, addr_i[ALIAS_BITS-1:0]}; // RQ4
   assign st_hi = st_lo + ((ALIAS_BITS+1)'(1) << ent_i.size_log);
   assign ld_hi = ld_lo + ((ALIAS_BITS+1)'(1) << size_log_i);

   assign overlap_o = ent_i.valid && (st_lo < ld_hi) && (ld_lo < st_hi);
   assign exact_o   = overlap_o
                    && (st_lo == ld_lo) // RQ2
                    && (ent_i.size_log == size_log_i) // RQ2
                    && (size_log_i <= FWD_MAX_LOG) // RQ3
                    && ent_i.is_int && int_i; // RQ1

endmodule
`default_nettype wire

// ### rtl/lsft_top.sv
// Issue, store forwarding and segment throttle control of the load/store path.
//
// Summary of operation
// RQ1 - Forward store data only between integer operations, never FP or SIMD.
// RQ2 - Forward only when load and store have equal size and address.
// RQ3 - Stores wider than 8 bytes never forward; load uses cache.
// RQ4 - Forward match compares only the low 12 address bits.
// RQ5 - A 64-byte line is handled as 16 chunks of 4 bytes.
// RQ6 - Narrow accesses to different bytes of one chunk are delayed.
// RQ7 - Zero segment base is the fast case; non-zero bases are slowed.
// RQ8 - Base not line aligned: one memory operation per 9 cycles.
// RQ9 - Data segment, non-zero aligned base: one per two cycles.
// RQ10 - Extra segments F and G: one per two cycles, even zero base.
// RQ11 - String destination segment: two cycles as string target, else nine.
// RQ12 - Code and stack segments, non-zero aligned base: one per nine cycles.
// RQ13 - A load overlapping an unforwardable store is delayed and reissued.
// RQ14 - Push and pop update the stack pointer here, without microcode.
// RQ15 - In-order pipeline issuing up to two instructions per cycle.
// RQ16 - Pipelined FP multiply and add ops issue back to back.
// RQ17 - Cache hazards make a long op that blocks all later issue.
// RQ18 - Per-pipeline counter spaces memory ops by the segment interval.
// RQ19 - A refused load waits for the store to drain, then reads cache.
`timescale 1ns/1ps
`default_nettype none
module lsft_top #(
   parameter int SB_N = lsft_pkg::SB_DEPTH
) (
   input  wire logic                  clk_i,          // Core clock, 40 MHz.
   input  wire logic                  sys_rst_i,      // Asynchronous reset, high.
   input  wire lsft_pkg::lsft_op_type op0_i,          // Older issue slot.
   input  wire lsft_pkg::lsft_op_type op1_i,          // Younger issue slot.
   input  wire logic                  cache_hazard_i, // Pending load met a hazard.
   input  wire logic                  cache_done_i,   // Long access finished.
   input  wire logic                  sb_drain_i,     // Oldest store written.
   input  wire logic                  sp_wr_i,        // Stack pointer write.
   input  wire logic [31:0]           sp_wdata_i,     // Stack pointer value.
   output logic                       issue0_o,       // Slot 0 issues.
   output logic                       issue1_o,       // Slot 1 issues.
   output lsft_pkg::lsft_req_type     mem_req_o,      // Load request to cache.
   output logic                       fwd_valid_o,    // Forwarded data valid.
   output logic [63:0]                fwd_data_o,     // Forwarded data.
   output logic                       reissue_o,      // Load refused, reissued.
   output logic                       long_busy_o,    // Long op blocks issue.
   output lsft_pkg::lsft_sb_type      sb_head_o,      // Oldest buffered store.
   output logic [31:0]                sp_o            // Stack pointer.
);
   import lsft_pkg::*;

   localparam int IDX_W = (SB_N > 1) ? $clog2(SB_N) : 1;
   localparam int CNT_W = $clog2(SB_N + 1);
   localparam logic [CNT_W-1:0] SB_FULL = CNT_W'(SB_N);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   generate
      if (SB_N < 1 || SB_N > 16) begin : g_bad_depth
         $error("SB_N must lie between 1 and 16");
      end
   endgenerate

   lsft_state_type   state_r;
   lsft_state_type   state_nxt;
   lsft_sb_type      sb_r [SB_N];
   lsft_sb_type      sb_nxt [SB_N];
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [31:0]      sp_r;
   logic [31:0]      sp_nxt;
   lsft_req_type     req_r;
   logic             fwd_valid_r;
   logic [63:0]      fwd_data_r;
   logic             wait_r;
   logic             chunk_wait_r;
   logic [29:0]      last_word_r;
   logic [3:0]       last_mask_r;
   logic             last_narrow_r;

   wire logic        mem0_w;
   wire logic        mem1_w;
   wire logic        slot1_w;
   lsft_op_type      msel;
   wire logic        mem_any_w;
   wire logic        ld_w;
   wire logic        st_w;
   wire logic        base_zero_w;
   wire logic        base_line_w;
   wire logic        seg_fg_w;
   logic [GAP_W-1:0] gap_w;
   logic [31:0]      sz_w;
   logic [31:0]      lin_w;
   logic [3:0]       chunk_w;
   logic [3:0]       mask_w;
   wire logic        narrow_w;
   wire logic        chunk_hold_w;
   logic [SB_N-1:0]  ovl_w;
   logic [SB_N-1:0]  exact_w;
   logic             hit_any;
   logic [IDX_W-1:0] hit_idx;
   wire logic        fwd_ok_w;
   wire logic        conflict_w;
   wire logic        st_full_w;
   wire logic        rdy0_w;
   wire logic        rdy1_w;
   wire logic        thr_ok_w;
   wire logic        hazard_w;
   wire logic        run_w;
   wire logic        mem_go_w;
   wire logic        drain_w;
   lsft_sb_type      new_ent_w;

   // Only one memory port: slot 1 carries a memory op only if slot 0 does not.
   assign mem0_w    = op0_i.valid && (op0_i.kind == KIND_MEM);
   assign mem1_w    = op1_i.valid && (op1_i.kind == KIND_MEM);
   assign slot1_w   = !mem0_w && mem1_w;
   assign msel      = mem0_w ? op0_i : op1_i;
   assign mem_any_w = mem0_w || mem1_w;
   assign ld_w      = mem_any_w && !msel.is_store;
   assign st_w      = mem_any_w && msel.is_store;

   assign base_zero_w = (msel.base == 32'h0000_0000); // RQ7
   assign base_line_w = (msel.base[LINE_OFS_W-1:0] == '0);
   assign seg_fg_w    = (msel.seg == EXTRA_SEGMENT_F) || (msel.seg == EXTRA_SEGMENT_G);

   // Spacing demanded by the segment and the alignment of its base.
   assign gap_w = !base_line_w ? GAP_SLOW // RQ8
      : seg_fg_w ? GAP_FAST // RQ10
      : base_zero_w ? GAP_FREE // RQ7
      : (msel.seg == DATA_SEGMENT) ? GAP_FAST // RQ9
      : (msel.seg == STRING_DEST_SEGMENT && msel.str_dst) ? GAP_FAST // RQ11
      : GAP_SLOW; // RQ11 RQ12

   // The address unit forms push and pop addresses from its own stack pointer.
   assign sz_w  = 32'h0000_0001 << msel.size_log;
   assign lin_w = msel.push ? sp_r - sz_w // RQ14
                : msel.pop ? sp_r // RQ14
                : msel.base + msel.addr;

   // Chunk index within the line and bytes touched inside that chunk.
   assign chunk_w  = lin_w[LINE_OFS_W-1:CHUNK_OFS_W]; // RQ5
   assign narrow_w = msel.size_log < WORD_LOG;
   assign mask_w   = narrow_w ? (4'((4'h1 << sz_w[2:0]) - 4'h1) << lin_w[1:0]) : 4'hF;
   assign chunk_hold_w = mem_any_w && narrow_w && last_narrow_r && !chunk_wait_r
                       && ({lin_w[31:LINE_OFS_W], chunk_w} == last_word_r)
                       && (mask_w != last_mask_r); // RQ6

   genvar g;
   generate
      for (g = 0; g < SB_N; g++) begin : g_cmp
         lsft_fwd_cmp u_cmp (
            .ent_i      (sb_r[g]),
            .addr_i     (lin_w),
            .size_log_i (msel.size_log),
            .int_i      (msel.is_int),
            .overlap_o  (ovl_w[g]),
            .exact_o    (exact_w[g])
         );
      end
   endgenerate

   // The youngest overlapping store decides; later entries are younger.
   always_comb begin
      hit_any = 1'b0;
      hit_idx = '0;
      for (int i = 0; i < SB_N; i++) begin
         if (ovl_w[i]) begin
            hit_any = 1'b1;
            hit_idx = IDX_W'(i);
         end
      end
   end

   assign fwd_ok_w   = ld_w && hit_any && exact_w[hit_idx]; // RQ1 RQ2 RQ3
   assign conflict_w = ld_w && hit_any && !exact_w[hit_idx]; // RQ13 RQ19
   assign st_full_w  = st_w && (cnt_r == SB_FULL);

   lsft_throttle u_thr0 (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .gap_i     (gap_w),
      .fire_i    (mem_go_w && !slot1_w),
      .ready_o   (rdy0_w)
   );

   lsft_throttle u_thr1 (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .gap_i     (gap_w),
      .fire_i    (mem_go_w && slot1_w),
      .ready_o   (rdy1_w)
   );

   assign thr_ok_w = slot1_w ? rdy1_w : rdy0_w; // RQ18

   // A hazard on the pending load stops issue in the very cycle it is seen.
   assign hazard_w    = req_r.valid && cache_hazard_i; // RQ17
   assign run_w       = (state_r == ST_RUN) && !hazard_w; // RQ17
   assign long_busy_o = !run_w;

   assign mem_go_w = run_w && mem_any_w && thr_ok_w && !st_full_w
                   && !conflict_w && !chunk_hold_w; // RQ13 RQ19

   // Non-memory ops, pipelined FP multiply and add among them, wait only for a long op and, in slot 1, for slot 0.
   assign issue0_o = op0_i.valid && run_w && (!mem0_w || mem_go_w); // RQ16
   assign issue1_o = op1_i.valid && issue0_o
                   && (!mem1_w || (slot1_w && mem_go_w)); // RQ15

   assign reissue_o = conflict_w && run_w && !wait_r; // RQ13

   always_comb begin
      unique case (state_r)
         ST_RUN:  state_nxt = hazard_w ? ST_LONG : ST_RUN;
         ST_LONG: state_nxt = cache_done_i ? ST_RUN : ST_LONG;
      endcase
   end

   assign new_ent_w = '{valid: 1'b1, is_int: msel.is_int, size_log: msel.size_log,
                        addr: lin_w, data: msel.data};
   assign drain_w   = sb_drain_i && (cnt_r != '0);

   // Store buffer shifts toward entry 0 as the cache takes the oldest store.
   always_comb begin
      sb_nxt  = sb_r;
      cnt_nxt = cnt_r;
      if (drain_w) begin
         for (int i = 0; i < SB_N - 1; i++) begin
            sb_nxt[i] = sb_r[i+1];
         end
         sb_nxt[SB_N-1] = '0;
         cnt_nxt = cnt_r - CNT_ONE;
      end
      if (mem_go_w && st_w) begin
         sb_nxt[IDX_W'(cnt_nxt)] = new_ent_w;
         cnt_nxt = cnt_nxt + CNT_ONE;
      end
   end

   always_comb begin
      sp_nxt = sp_r;
      if (sp_wr_i) begin
         sp_nxt = sp_wdata_i;
      end else if (mem_go_w && msel.push) begin
         sp_nxt = sp_r - sz_w; // RQ14
      end else if (mem_go_w && msel.pop) begin
         sp_nxt = sp_r + sz_w; // RQ14
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_RUN;
         cnt_r   <= '0;
         sp_r    <= SP_RST;
         for (int i = 0; i < SB_N; i++) begin
            sb_r[i] <= '0;
         end
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         sp_r    <= sp_nxt;
         sb_r    <= sb_nxt;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_r        <= '0;
         fwd_valid_r  <= 1'b0;
         fwd_data_r   <= '0;
         wait_r       <= 1'b0;
         chunk_wait_r <= 1'b0;
      end else begin
         req_r.valid    <= mem_go_w && ld_w && !fwd_ok_w; // RQ3 RQ19
         req_r.size_log <= msel.size_log;
         req_r.addr     <= lin_w;
         fwd_valid_r    <= mem_go_w && fwd_ok_w;
         fwd_data_r     <= sb_r[hit_idx].data;
         wait_r         <= conflict_w;
         chunk_wait_r   <= chunk_hold_w; // RQ6
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_word_r   <= '0;
         last_mask_r   <= '0;
         last_narrow_r <= 1'b0;
      end else if (mem_go_w) begin
         last_word_r   <= lin_w[31:CHUNK_OFS_W];
         last_mask_r   <= mask_w;
         last_narrow_r <= narrow_w;
      end
   end

   assign mem_req_o   = req_r;
   assign fwd_valid_o = fwd_valid_r;
   assign fwd_data_o  = fwd_data_r;
   assign sb_head_o   = sb_r[0];
   assign sp_o        = sp_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_no_fp_fwd: assert property ( // RQ1
      mem_go_w && ld_w && !msel.is_int |=> !fwd_valid_o && !$past(fwd_ok_w))
      else $error("non-integer load received forwarded data");

   a_fwd_same_size: assert property ( // RQ2
      fwd_ok_w |-> sb_r[hit_idx].size_log == msel.size_log)
      else $error("forward between different sizes");

   a_fwd_max_width: assert property ( // RQ3
      mem_go_w && ld_w && msel.size_log > 3'h3 |=> !fwd_valid_o && mem_req_o.valid)
      else $error("wide load was forwarded");

   a_alias_low: assert property ( // RQ4
      fwd_ok_w |-> sb_r[hit_idx].addr[11:0] == lin_w[11:0])
      else $error("forward address mismatch in low bits");

   a_reissue_hold: assert property ( // RQ13
      reissue_o |-> !issue0_o ##1 !fwd_valid_o && !mem_req_o.valid)
      else $error("refused load was issued");

   a_long_block: assert property ( // RQ17
      hazard_w |-> !issue0_o && !issue1_o ##1 long_busy_o)
      else $error("issue during long memory op");

   a_in_order: assert property ( // RQ15
      issue1_o |-> issue0_o)
      else $error("younger slot issued alone");

   a_chunk_delay: assert property ( // RQ6
      chunk_hold_w |-> !mem_go_w ##1 chunk_wait_r)
      else $error("chunk byte conflict not delayed");

endmodule
`default_nettype wire

// ### sim/lsft_cache_model.sv
// Behavioural cache and store-buffer partner for the load/store forward throttle.
`timescale 1ns/1ps
`default_nettype none
module lsft_cache_model (
   input  wire logic                   clk_i,          // Core clock.
   input  wire logic                   sys_rst_i,      // Asynchronous reset, high.
   input  wire lsft_pkg::lsft_req_type mem_req_i,      // Load request from block.
   input  wire lsft_pkg::lsft_sb_type  sb_head_i,      // Oldest buffered store.
   input  wire logic                   hold_i,         // Stall store writes.
   input  wire logic                   hazard_en_i,    // Report hazards on loads.
   input  wire logic [3:0]             done_lat_i,     // Long access length.
   output logic                        cache_hazard_o, // Hazard on this load.
   output logic                        cache_done_o,   // Long access finished.
   output logic                        sb_drain_o      // Oldest store written.
);
   import lsft_pkg::*;
   logic [3:0] cnt_r;
   logic       ph_r;
   assign cache_hazard_o = hazard_en_i && mem_req_i.valid;
   assign cache_done_o   = (cnt_r == 4'h1);
   // Writes land every other cycle so the block always meets a slow cache.
   assign sb_drain_o = sb_head_i.valid && !hold_i && ph_r;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= 4'h0;
         ph_r  <= 1'b0;
      end else begin
         ph_r <= !ph_r;
         if (cache_hazard_o) begin
            cnt_r <= done_lat_i;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/load_store_forward_throttle_tb.sv
// Self-checking testbench for the load/store forward throttle.
`timescale 1ns/1ps
`default_nettype none
module load_store_forward_throttle_tb;
   import lsft_pkg::*;
   logic         clk_i, sys_rst_i, hz, dn, dr, sp_wr_i, hold, hz_en;
   logic [3:0]   dlat;
   logic [31:0]  sp_wdata_i, sp_o;
   lsft_op_type  op0_i, op1_i;
   logic         issue0_o, issue1_o, fwd_valid_o, reissue_o, long_busy_o;
   logic [63:0]  fwd_data_o;
   lsft_req_type mem_req_o;
   lsft_sb_type  sb_head_o;
   int           err_count, checks_done;

   lsft_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op0_i(op0_i), .op1_i(op1_i),
      .cache_hazard_i(hz), .cache_done_i(dn), .sb_drain_i(dr), .sp_wr_i(sp_wr_i),
      .sp_wdata_i(sp_wdata_i), .issue0_o(issue0_o), .issue1_o(issue1_o),
      .mem_req_o(mem_req_o), .fwd_valid_o(fwd_valid_o), .fwd_data_o(fwd_data_o),
      .reissue_o(reissue_o), .long_busy_o(long_busy_o), .sb_head_o(sb_head_o),
      .sp_o(sp_o));
   lsft_cache_model PEER (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mem_req_i(mem_req_o),
      .sb_head_i(sb_head_o), .hold_i(hold), .hazard_en_i(hz_en), .done_lat_i(dlat),
      .cache_hazard_o(hz), .cache_done_o(dn), .sb_drain_o(dr));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = !clk_i;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   function automatic lsft_op_type mk(lsft_kind_type k, logic st, logic it,
         lsft_seg_type sg, logic [31:0] b, logic [31:0] a, logic [2:0] sz);
      lsft_op_type m;
      m = '0;
      m.valid = 1'b1;
      m.kind = k;
      m.is_store = st;
      m.is_int = it;
      m.seg = sg;
      m.base = b;
      m.addr = a;
      m.size_log = sz;
      m.data = {32'h0000_0000, a ^ 32'h5A5A_C3C3};
      return m;
   endfunction

   // Presents an op in slot 0 and returns at the negedge of the cycle it issues.
   task automatic iss0(lsft_op_type op, output int n);
      @(posedge clk_i);
      op0_i <= op;
      n = 0;
      @(negedge clk_i);
      while (issue0_o !== 1'b1 && n < 40) begin
         n++;
         @(negedge clk_i);
      end
      if (n == 40) chk("issue wait", 0, 1);
   endtask

   task automatic idle(int c);
      @(posedge clk_i);
      op0_i <= '0;
      op1_i <= '0;
      repeat (c) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic thr(lsft_seg_type sg, logic [31:0] b, logic sd, logic [2:0] sz,
         logic [31:0] a2, int gap);
      lsft_op_type o;
      int n;
      o = mk(KIND_MEM, 1'b0, 1'b1, sg, b, 32'h100, sz);
      o.str_dst = sd;
      iss0(o, n);
      o.addr = a2;
      iss0(o, n);
      chk("issue spacing", gap, n + 1);
      idle(10);
      $display("test spacing seg %0d base %h done", sg, b);
   endtask

   task automatic fwd(logic [31:0] a_st, logic [31:0] a_ld);
      lsft_op_type s;
      int n;
      @(posedge clk_i);
      hold <= 1'b1;
      s = mk(KIND_MEM, 1'b1, 1'b1, DATA_SEGMENT, 32'h0, a_st, 3'h2);
      iss0(s, n);
      iss0(mk(KIND_MEM, 1'b0, 1'b1, DATA_SEGMENT, 32'h0, a_ld, 3'h2), n);
      chk("forward load held", 0, n);
      @(posedge clk_i);
      op0_i <= '0;
      hold <= 1'b0;
      @(negedge clk_i);
      chk("fwd_valid_o", 1, fwd_valid_o);
      chk("fwd_data_o", s.data, fwd_data_o);
      chk("mem_req_o valid", 0, mem_req_o.valid);
      idle(12);
      $display("test forward %h to %h done", a_st, a_ld);
   endtask

   task automatic rfs(logic si, logic [2:0] ss, logic [2:0] ls);
      lsft_op_type l;
      int n;
      @(posedge clk_i);
      hold <= 1'b1;
      iss0(mk(KIND_MEM, 1'b1, si, DATA_SEGMENT, 32'h0, 32'h240, ss), n);
      l = mk(KIND_MEM, 1'b0, si, DATA_SEGMENT, 32'h0, 32'h240, ls);
      @(posedge clk_i);
      op0_i <= l;
      @(negedge clk_i);
      chk("refused load issue0_o", 0, issue0_o);
      chk("reissue_o", 1, reissue_o);
      repeat (4) @(negedge clk_i);
      chk("load held before drain", 0, issue0_o);
      @(posedge clk_i);
      hold <= 1'b0;
      iss0(l, n);
      @(posedge clk_i);
      op0_i <= '0;
      @(negedge clk_i);
      chk("mem_req_o valid", 1, mem_req_o.valid);
      chk("mem_req_o addr", 32'h240, mem_req_o.addr);
      chk("mem_req_o size", ls, mem_req_o.size_log);
      chk("fwd_valid_o", 0, fwd_valid_o);
      idle(12);
      $display("test refusal int %0d sizes %0d %0d done", si, ss, ls);
   endtask

   task automatic dual();
      lsft_op_type a;
      a = mk(KIND_ALU, 1'b0, 1'b1, DATA_SEGMENT, 32'h0, 32'h0, 3'h0);
      @(posedge clk_i);
      op0_i <= a;
      op1_i <= a;
      @(negedge clk_i);
      chk("two alu issue", 2'b11, {issue0_o, issue1_o});
      @(posedge clk_i);
      op0_i <= mk(KIND_FPPIPE, 1'b0, 1'b0, DATA_SEGMENT, 32'h0, 32'h0, 3'h0);
      op1_i <= mk(KIND_FPPIPE, 1'b0, 1'b0, DATA_SEGMENT, 32'h0, 32'h0, 3'h0);
      repeat (2) begin
         @(negedge clk_i);
         chk("fp back to back", 2'b11, {issue0_o, issue1_o});
      end
      @(posedge clk_i);
      op0_i <= mk(KIND_MEM, 1'b0, 1'b1, DATA_SEGMENT, 32'h0, 32'h400, 3'h2);
      op1_i <= mk(KIND_MEM, 1'b0, 1'b1, DATA_SEGMENT, 32'h0, 32'h500, 3'h2);
      @(negedge clk_i);
      chk("two mem ops", 2'b10, {issue0_o, issue1_o});
      @(posedge clk_i);
      op0_i <= '0;
      op1_i <= a;
      @(negedge clk_i);
      chk("slot1 alone", 0, issue1_o);
      idle(4);
      $display("test dual issue done");
   endtask

   task automatic long_op();
      int n;
      @(posedge clk_i);
      hz_en <= 1'b1;
      dlat <= 4'h4;
      iss0(mk(KIND_MEM, 1'b0, 1'b1, DATA_SEGMENT, 32'h0, 32'h600, 3'h2), n);
      @(posedge clk_i);
      op0_i <= mk(KIND_ALU, 1'b0, 1'b1, DATA_SEGMENT, 32'h0, 32'h0, 3'h0);
      @(negedge clk_i);
      chk("long_busy_o", 1, long_busy_o);
      chk("alu blocked", 0, issue0_o);
      @(posedge clk_i);
      hz_en <= 1'b0;
      n = 0;
      @(negedge clk_i);
      while (issue0_o !== 1'b1 && n < 20) begin
         n++;
         @(negedge clk_i);
      end
      chk("blocked cycles", 4, n);
      chk("long_busy_o after done", 0, long_busy_o);
      idle(4);
      $display("test long operation done");
   endtask

   task automatic stack();
      int n;
      lsft_op_type p;
      @(posedge clk_i);
      sp_wr_i <= 1'b1;
      sp_wdata_i <= 32'h0000_0100;
      @(posedge clk_i);
      sp_wr_i <= 1'b0;
      p = mk(KIND_MEM, 1'b1, 1'b1, STACK_SEGMENT, 32'h0, 32'h0, 3'h2);
      p.push = 1'b1;
      iss0(p, n);
      idle(0);
      chk("sp after push", 32'h0000_00FC, sp_o);
      chk("push addr", 32'h0000_00FC, sb_head_o.addr);
      idle(10);
      p = mk(KIND_MEM, 1'b0, 1'b1, STACK_SEGMENT, 32'h0, 32'h0, 3'h2);
      p.pop = 1'b1;
      iss0(p, n);
      idle(0);
      chk("pop addr", 32'h0000_00FC, mem_req_o.addr);
      chk("sp after pop", 32'h0000_0100, sp_o);
      idle(4);
      $display("test stack done");
   endtask

   initial begin
      #(25 * 20000);
      err_count++;
      $display("[FAIL] watchdog expected finish seen hang");
      end_of_test();
   end

   initial begin
      err_count = 0;
      checks_done = 0;
      sys_rst_i = 1'b1;
      op0_i = '0;
      op1_i = '0;
      sp_wr_i = 1'b0;
      sp_wdata_i = 32'h0;
      hold = 1'b0;
      hz_en = 1'b0;
      dlat = 4'h4;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      idle(2);
      thr(DATA_SEGMENT, 32'h0, 1'b0, 3'h2, 32'h200, 1);
      thr(DATA_SEGMENT, 32'h40, 1'b0, 3'h2, 32'h200, 2);
      thr(DATA_SEGMENT, 32'h44, 1'b0, 3'h2, 32'h200, 9);
      thr(EXTRA_SEGMENT_F, 32'h0, 1'b0, 3'h2, 32'h200, 2);
      thr(EXTRA_SEGMENT_G, 32'h80, 1'b0, 3'h2, 32'h200, 2);
      thr(STRING_DEST_SEGMENT, 32'h40, 1'b1, 3'h2, 32'h200, 2);
      thr(STRING_DEST_SEGMENT, 32'h40, 1'b0, 3'h2, 32'h200, 9);
      thr(CODE_SEGMENT, 32'h40, 1'b0, 3'h2, 32'h200, 9);
      thr(STACK_SEGMENT, 32'h40, 1'b0, 3'h2, 32'h200, 9);
      thr(DATA_SEGMENT, 32'h0, 1'b0, 3'h0, 32'h101, 2);
      thr(DATA_SEGMENT, 32'h0, 1'b0, 3'h0, 32'h104, 1);
      fwd(32'h0000_1234, 32'h0000_1234);
      fwd(32'h0000_1234, 32'h0000_5234);
      rfs(1'b1, 3'h2, 3'h3);
      rfs(1'b0, 3'h2, 3'h2);
      rfs(1'b1, 3'h4, 3'h4);
      dual();
      long_op();
      stack();
      end_of_test();
   end
endmodule
`default_nettype wire
